// file: tpf_core_model.sv
`timescale 1ns/10ps
module tpf_core_model (
   input wire logic clk_i,
   input wire logic ab_rst_i,
   input wire logic ab_wr_i,
   input wire logic [35:0] ab_wdata_i,
   input wire logic ab_rd_i,
   output logic [17:0] ab_rdata_o,
   input wire logic ca_rst_i,
   input wire logic ca_wr_i,
   input wire logic [17:0] ca_wdata_i,
   input wire logic ca_rd_i,
   output logic [35:0] ca_rdata_o
);
   logic [7:0] ab_idx;
   logic [7:0] ca_idx;
   logic [35:0] ab_last;
   logic [17:0] ca_last;
   // Data follow the read pointer, so a missed or extra read shows as a wrong word
   assign ab_rdata_o = 18'h000a5 + {10'h000, ab_idx};
   assign ca_rdata_o = 36'h00000c3c3 + {28'h0000000, ca_idx};
   always_ff @(posedge clk_i)
   begin
      if (ab_rst_i)
         ab_idx <= 8'h00;
      else if (ab_rd_i)
         ab_idx <= ab_idx + 8'h01;
      if (ca_rst_i)
         ca_idx <= 8'h00;
      else if (ca_rd_i)
         ca_idx <= ca_idx + 8'h01;
      if (ab_wr_i)
         ab_last <= ab_wdata_i;
      if (ca_wr_i)
         ca_last <= ca_wdata_i;
   end
endmodule : tpf_core_model

// file: tpf_ctrl.sv
`timescale 1ns/10ps
`include "tpf_params.svh"
// How it works
// [RQ1] Master reset picks preset, parallel or serial
// [RQ2] Serial enable low shifts bit per clock
// [RQ3] Programmer sends 32, 36 or 40 bits
// [RQ4] First bit Y1 MSB, last X2 LSB
// [RQ5] Port A mailbox select routes second mailbox
// [RQ6] Port B mailbox select routes first mailbox
// [RQ7] Port C mailbox select writes second mailbox
// [RQ8] Port A mailbox write drops flag, blocks
// [RQ9] Port B mailbox read or reset raises flag
// [RQ10] Second mailbox flag, same scheme, other ports
// [RQ11] First queue reset clears pointers, B output
// [RQ12] Master reset release latches configuration
// [RQ13] Four A and B edges during reset
// [RQ14] Second queue reset clears pointers, A output
// [RQ15] Second master reset released with first
// [RQ16] Four A and C edges during reset
// [RQ17] Partial reset keeps configuration and offsets
// [RQ18] Port B read needs read enable
// [RQ19] Port C write needs write enable
// [RQ20] Width select high byte, low word
// [RQ21] Serial select low means serial programming
// [RQ22] Port A write select floats outputs
// [RQ23] Port A needs enable and chip select
// [RQ24] Endian in reset, timing mode after
// [RQ25] Fixed decode table for offset selects
module tpf_ctrl #(
   parameter int DEPTH_LOG2 = `TPF_DEPTH_LOG2
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic port_a_clock_i,
   input wire logic port_b_clock_i,
   input wire logic port_c_clock_i,
   input wire logic master_reset_one_n_i,
   input wire logic master_reset_two_n_i,
   input wire logic partial_reset_one_n_i,
   input wire logic partial_reset_two_n_i,
   input wire logic offset_sel_hi_serial_enable_i,
   input wire logic offset_sel_lo_serial_bit_i,
   input wire logic serial_prog_select_n_i,
   input wire logic endian_timing_select_i,
   input wire logic port_b_width_select_i,
   input wire logic port_c_width_select_i,
   input wire logic port_a_enable_i,
   input wire logic port_a_chip_select_n_i,
   input wire logic port_a_write_not_read_i,
   input wire logic port_a_mailbox_select_i,
   input wire logic port_b_read_enable_i,
   input wire logic port_b_mailbox_select_i,
   input wire logic port_c_write_enable_i,
   input wire logic port_c_mailbox_select_i,
   input wire logic [`TPF_A_W-1:0] port_a_data_i,
   input wire logic [`TPF_BC_W-1:0] port_c_data_i,
   output logic [`TPF_A_W-1:0] port_a_data_o,
   output logic port_a_data_oe_o,
   output logic [`TPF_BC_W-1:0] port_b_data_o,
   output logic first_mailbox_flag_n_o,
   output logic second_mailbox_flag_n_o,
   output tpf_pkg::tpf_cfg_s cfg_o,
   output logic [4*DEPTH_LOG2-1:0] offsets_o,
   output logic a_to_b_queue_ptr_rst_o,
   output logic a_to_b_queue_write_o,
   output logic [`TPF_A_W-1:0] a_to_b_queue_wdata_o,
   output logic a_to_b_queue_read_o,
   input wire logic [`TPF_BC_W-1:0] a_to_b_queue_rdata_i,
   output logic c_to_a_queue_ptr_rst_o,
   output logic c_to_a_queue_write_o,
   output logic [`TPF_BC_W-1:0] c_to_a_queue_wdata_o,
   output logic c_to_a_queue_read_o,
   input wire logic [`TPF_A_W-1:0] c_to_a_queue_rdata_i
);
   localparam int OW = DEPTH_LOG2;
   localparam int SW = 4 * OW;

   if (DEPTH_LOG2 < `TPF_DEPTH_LOG2_MIN || DEPTH_LOG2 > `TPF_DEPTH_LOG2_MAX)
   begin : g_bad_depth
      $error("DEPTH_LOG2 out of range");
   end

   typedef struct packed {
      tpf_pkg::tpf_pins_s s1;
      tpf_pkg::tpf_pins_s s2;
      tpf_pkg::tpf_pins_s s3;
      tpf_pkg::tpf_pins_s f;
      tpf_pkg::tpf_cfg_s cfg;
      logic [SW-1:0] ofs;
      logic [5:0] nbits;
      logic [2:0] par_cnt;
      logic mb1_n;
      logic mb2_n;
      logic [`TPF_BC_W-1:0] first_mailbox;
      logic [`TPF_BC_W-1:0] second_mailbox;
      logic [`TPF_A_W-1:0] a_out;
      logic [`TPF_BC_W-1:0] b_out;
      logic [`TPF_A_W-1:0] a_dout;
      logic [`TPF_BC_W-1:0] b_dout;
      logic q1_rst;
      logic q2_rst;
      logic q1_wr;
      logic q1_rd;
      logic q2_wr;
      logic q2_rd;
      logic [`TPF_A_W-1:0] q1_wdata;
      logic [`TPF_BC_W-1:0] q2_wdata;
   } tpf_state_s;

   tpf_state_s r;
   tpf_state_s next_r;
   tpf_pkg::tpf_pins_s pins;
   tpf_pkg::tpf_pins_s nf;
   logic a_edge, b_edge, c_edge;
   logic master_reset_one_n_rise, master_reset_two_n_rise;
   logic q1_rst, q2_rst;
   logic a_go, a_wr, a_rd, b_go, c_go;
   logic par, par_ld, ser_sh;
   logic mb1_wr, mb1_rd, mb2_wr, mb2_rd;
   logic q1_wr, q1_rd, q2_wr, q2_rd;
   logic [`TPF_OFS_W-1:0] preset_now;

   // Offset-select decode; select lines low pick parallel loading
   function automatic logic [`TPF_OFS_W-1:0] preset_of(input logic hi, input logic lo);
      case ({hi, lo})
         2'b01: preset_of = `TPF_OFS_8;
         2'b10: preset_of = `TPF_OFS_16;
         2'b11: preset_of = `TPF_OFS_64;
         default: preset_of = `TPF_OFS_8;
      endcase
   endfunction : preset_of

   function automatic tpf_pkg::tpf_method_e method_of(input logic spm_n,
                                                      input logic hi, input logic lo);
      if (!spm_n)
         method_of = tpf_pkg::TPF_SERIAL; // [RQ21]
      else if (!hi && !lo)
         method_of = tpf_pkg::TPF_PARALLEL; // [RQ25]
      else
         method_of = tpf_pkg::TPF_PRESET;
   endfunction : method_of

   assign pins = '{
      a_clk: port_a_clock_i, b_clk: port_b_clock_i, c_clk: port_c_clock_i,
      master_reset_one_n_n: master_reset_one_n_i, master_reset_two_n_n: master_reset_two_n_i,
      partial_reset_one_n_n: partial_reset_one_n_i, partial_reset_two_n_n: partial_reset_two_n_i,
      sel_hi: offset_sel_hi_serial_enable_i, sel_lo: offset_sel_lo_serial_bit_i,
      spm_n: serial_prog_select_n_i, ets: endian_timing_select_i,
      b_byte: port_b_width_select_i, c_byte: port_c_width_select_i,
      a_en: port_a_enable_i, a_cs_n: port_a_chip_select_n_i,
      a_wr: port_a_write_not_read_i, a_mb: port_a_mailbox_select_i,
      b_ren: port_b_read_enable_i, b_mb: port_b_mailbox_select_i,
      c_wen: port_c_write_enable_i, c_mb: port_c_mailbox_select_i,
      a_data: port_a_data_i, c_data: port_c_data_i};

   // A pin change counts only once stages two and three agree
   assign nf = tpf_pkg::tpf_pins_s'(((r.s2 ~^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.f));

   assign a_edge = nf.a_clk & ~r.f.a_clk;
   assign b_edge = nf.b_clk & ~r.f.b_clk;
   assign c_edge = nf.c_clk & ~r.f.c_clk;
   assign master_reset_one_n_rise = nf.master_reset_one_n_n & ~r.f.master_reset_one_n_n;
   assign master_reset_two_n_rise = nf.master_reset_two_n_n & ~r.f.master_reset_two_n_n;
   assign q1_rst = ~nf.master_reset_one_n_n | ~nf.partial_reset_one_n_n; // [RQ11]
   assign q2_rst = ~nf.master_reset_two_n_n | ~nf.partial_reset_two_n_n; // [RQ14]

   assign a_go = a_edge & nf.a_en & ~nf.a_cs_n; // [RQ23]
   assign a_wr = a_go & nf.a_wr; // [RQ22]
   assign a_rd = a_go & ~nf.a_wr;
   assign par = (r.cfg.method == tpf_pkg::TPF_PARALLEL) && (r.par_cnt != 3'(`TPF_OFS_REGS));
   assign par_ld = a_wr & ~nf.a_mb & par & nf.master_reset_one_n_n;
   assign mb1_wr = a_wr & nf.a_mb & r.mb1_n & ~q1_rst; // [RQ8]
   assign q1_wr = a_wr & ~nf.a_mb & ~par & ~q1_rst;
   assign mb2_rd = a_rd & nf.a_mb; // [RQ5]
   assign q2_rd = a_rd & ~nf.a_mb & ~q2_rst;
   assign b_go = b_edge & nf.b_ren; // [RQ18]
   assign mb1_rd = b_go & nf.b_mb; // [RQ9]
   assign q1_rd = b_go & ~nf.b_mb & ~q1_rst;
   assign c_go = c_edge & nf.c_wen; // [RQ19]
   assign mb2_wr = c_go & nf.c_mb & r.mb2_n & ~q2_rst; // [RQ7] [RQ10]
   assign q2_wr = c_go & ~nf.c_mb & ~q2_rst;
   assign preset_now = preset_of(r.f.sel_hi, r.f.sel_lo);
   // Shifting stops at a full image so stray edges cannot shuffle it
   assign ser_sh = (r.cfg.method == tpf_pkg::TPF_SERIAL) && (r.nbits != 6'(SW))
                   && nf.master_reset_one_n_n && a_edge && !nf.sel_hi; // [RQ2] [RQ3]

   always_comb
   begin
      next_r = r;
      next_r.s1 = pins;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.f = nf;
      if (!nf.master_reset_one_n_n)
      begin
         next_r.nbits = '0;
         next_r.par_cnt = '0;
      end
      if (master_reset_one_n_rise)
      begin
         next_r.cfg.method = method_of(r.f.spm_n, r.f.sel_hi, r.f.sel_lo); // [RQ1] [RQ12]
         next_r.cfg.preset = preset_of(r.f.sel_hi, r.f.sel_lo);
         next_r.cfg.big_endian = r.f.ets; // [RQ24]
         next_r.cfg.b_byte = r.f.b_byte; // [RQ20]
         next_r.cfg.c_byte = r.f.c_byte;
         if (method_of(r.f.spm_n, r.f.sel_hi, r.f.sel_lo) == tpf_pkg::TPF_PRESET)
            next_r.ofs[SW-1:2*OW] = {2{preset_now[OW-1:0]}};
      end
      // Second queue offsets are set on its own release
      if (master_reset_two_n_rise && method_of(r.f.spm_n, r.f.sel_hi, r.f.sel_lo) == tpf_pkg::TPF_PRESET)
         next_r.ofs[2*OW-1:0] = {2{preset_now[OW-1:0]}}; // [RQ15]
      if (nf.master_reset_one_n_n)
         next_r.cfg.fwft = ~nf.ets; // [RQ24]
      if (ser_sh)
      begin
         next_r.ofs = {r.ofs[SW-2:0], nf.sel_lo}; // [RQ4]
         next_r.nbits = r.nbits + 6'h1;
      end
      else if (par_ld)
      begin
         next_r.ofs = {r.ofs[SW-OW-1:0], nf.a_data[OW-1:0]};
         next_r.par_cnt = r.par_cnt + 3'h1;
      end
      // Hardware set of a flag wins over a read in the same cycle
      if (q1_rst)
         next_r.mb1_n = `TPF_FLAG_EMPTY; // [RQ9]
      else if (mb1_wr)
      begin
         next_r.first_mailbox = nf.a_data[`TPF_BC_W-1:0];
         next_r.mb1_n = 1'b0; // [RQ8]
      end
      else if (mb1_rd)
         next_r.mb1_n = 1'b1; // [RQ9]
      if (q2_rst)
         next_r.mb2_n = `TPF_FLAG_EMPTY; // [RQ10]
      else if (mb2_wr)
      begin
         next_r.second_mailbox = nf.c_data;
         next_r.mb2_n = 1'b0; // [RQ10]
      end
      else if (mb2_rd)
         next_r.mb2_n = 1'b1; // [RQ10]
      if (q1_rst)
         next_r.b_out = '0; // [RQ11]
      else if (q1_rd)
         next_r.b_out = a_to_b_queue_rdata_i;
      if (q2_rst)
         next_r.a_out = `TPF_OUT_CLR; // [RQ14]
      else if (q2_rd)
         next_r.a_out = c_to_a_queue_rdata_i;
      next_r.b_dout = nf.b_mb ? r.first_mailbox : r.b_out; // [RQ6]
      next_r.a_dout = nf.a_mb ? {{(`TPF_A_W-`TPF_BC_W){1'b0}}, r.second_mailbox} : r.a_out; // [RQ5]
      next_r.q1_rst = q1_rst;
      next_r.q2_rst = q2_rst;
      next_r.q1_wr = q1_wr;
      next_r.q1_rd = q1_rd;
      next_r.q2_wr = q2_wr;
      next_r.q2_rd = q2_rd;
      if (q1_wr)
         next_r.q1_wdata = nf.a_data;
      if (q2_wr)
         next_r.q2_wdata = nf.c_data;
   end

   // Filtered pins start low, so both resets look active until pins settle
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         r <= '0;
         r.mb1_n <= `TPF_FLAG_EMPTY;
         r.mb2_n <= `TPF_FLAG_EMPTY;
         // Chip select starts idle so port A is not driven straight out of reset
         r.s1.a_cs_n <= 1'b1;
         r.s2.a_cs_n <= 1'b1;
         r.s3.a_cs_n <= 1'b1;
         r.f.a_cs_n <= 1'b1;
      end
      else
         r <= next_r;
   end

   assign port_a_data_o = r.a_dout;
   assign port_a_data_oe_o = ~r.f.a_cs_n & ~r.f.a_wr; // [RQ22]
   assign port_b_data_o = r.b_dout;
   assign first_mailbox_flag_n_o = r.mb1_n;
   assign second_mailbox_flag_n_o = r.mb2_n;
   assign cfg_o = r.cfg;
   assign offsets_o = r.ofs;
   assign a_to_b_queue_ptr_rst_o = r.q1_rst;
   assign a_to_b_queue_write_o = r.q1_wr;
   assign a_to_b_queue_wdata_o = r.q1_wdata;
   assign a_to_b_queue_read_o = r.q1_rd;
   assign c_to_a_queue_ptr_rst_o = r.q2_rst;
   assign c_to_a_queue_write_o = r.q2_wr;
   assign c_to_a_queue_wdata_o = r.q2_wdata;
   assign c_to_a_queue_read_o = r.q2_rd;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   chk_mb1_write_low: assert property (mb1_wr |=> !first_mailbox_flag_n_o) // [RQ8]
      else $error("mailbox one flag not low after write");
   chk_mb1_write_block: assert property ( // [RQ8]
      !r.mb1_n && !q1_rst |=> $stable(r.first_mailbox))
      else $error("mailbox one overwritten while full");
   chk_mb1_read_free: assert property ( // [RQ9]
      mb1_rd && !q1_rst && !mb1_wr |=> first_mailbox_flag_n_o)
      else $error("mailbox one flag not released");
   chk_q1_reset_clear: assert property ( // [RQ11]
      q1_rst |=> r.mb1_n && r.b_out == '0 && a_to_b_queue_ptr_rst_o)
      else $error("first queue reset incomplete");
   chk_q1_write_hold: assert property (q1_rst |=> !a_to_b_queue_write_o) // [RQ11]
      else $error("first queue written during reset");
   chk_q2_reset_clear: assert property ( // [RQ14]
      q2_rst |=> second_mailbox_flag_n_o && r.a_out == '0)
      else $error("second queue reset incomplete");
   chk_q2_ptr_level: assert property (q2_rst |=> c_to_a_queue_ptr_rst_o) // [RQ14]
      else $error("second queue pointers not held in reset");
   chk_mb2_write_low: assert property ( // [RQ10]
      mb2_wr |=> !second_mailbox_flag_n_o && r.second_mailbox == $past(nf.c_data))
      else $error("mailbox two write wrong");
   chk_mb2_read_free: assert property ( // [RQ10]
      mb2_rd && !q2_rst && !mb2_wr |=> second_mailbox_flag_n_o)
      else $error("mailbox two flag not released");
   chk_a_float: assert property (r.f.a_wr |-> !port_a_data_oe_o) // [RQ22]
      else $error("port A driven during write");
   chk_b_read_gate: assert property ( // [RQ18]
      a_to_b_queue_read_o |-> $past(b_edge) && $past(nf.b_ren))
      else $error("queue read without read enable");
   chk_c_write_gate: assert property (c_to_a_queue_write_o |-> $past(c_go)) // [RQ19]
      else $error("queue write without write enable");
   chk_a_access_gate: assert property (a_to_b_queue_write_o |-> $past(a_go)) // [RQ23]
      else $error("port A write without enable");
   chk_serial_shift: assert property (ser_sh |=> r.ofs[0] == $past(nf.sel_lo)) // [RQ2]
      else $error("serial bit not shifted in");
   chk_cfg_latch: assert property ( // [RQ12]
      master_reset_one_n_rise |=> r.cfg.b_byte == $past(r.f.b_byte)
      && r.cfg.big_endian == $past(r.f.ets))
      else $error("configuration not latched");
   chk_partial_keep: assert property ( // [RQ17]
      nf.master_reset_one_n_n && r.f.master_reset_one_n_n && !nf.partial_reset_one_n_n |=> $stable(r.cfg.method)
      && $stable(r.cfg.b_byte))
      else $error("partial reset changed configuration");
endmodule : tpf_ctrl

// file: tpf_ctrl_bench.sv
`timescale 1ns/10ps
`include "tpf_params.svh"
module tpf_ctrl_bench;
   logic clk_i, srst_i, pa, pb, pc, master_reset_one_n_n, master_reset_two_n_n, partial_reset_one_n_n, partial_reset_two_n_n, hi, lo, spm_n, ets, bw, cw;
   logic a_en, a_cs_n, a_wr, a_mb, b_ren, b_mb, c_wen, c_mb, a_oe, mf1, mf2;
   logic ab_rst, ab_wr, ab_rd, ca_rst, ca_wr, ca_rd;
   logic [35:0] a_drv, a_do, ab_wd, ca_rdat;
   logic [17:0] c_drv, b_do, ca_wd, ab_rdat;
   logic [31:0] ofs;
   tpf_pkg::tpf_cfg_s cfg;
   int miscompares = 0;
   int num_checks = 0;
   tpf_ctrl #(.DEPTH_LOG2(8)) uut (.clk_i(clk_i), .srst_i(srst_i), .port_a_clock_i(pa),
      .port_b_clock_i(pb), .port_c_clock_i(pc), .master_reset_one_n_i(master_reset_one_n_n),
      .master_reset_two_n_i(master_reset_two_n_n), .partial_reset_one_n_i(partial_reset_one_n_n),
      .partial_reset_two_n_i(partial_reset_two_n_n), .offset_sel_hi_serial_enable_i(hi),
      .offset_sel_lo_serial_bit_i(lo), .serial_prog_select_n_i(spm_n),
      .endian_timing_select_i(ets), .port_b_width_select_i(bw), .port_c_width_select_i(cw),
      .port_a_enable_i(a_en), .port_a_chip_select_n_i(a_cs_n), .port_a_write_not_read_i(a_wr),
      .port_a_mailbox_select_i(a_mb), .port_b_read_enable_i(b_ren),
      .port_b_mailbox_select_i(b_mb), .port_c_write_enable_i(c_wen),
      .port_c_mailbox_select_i(c_mb), .port_a_data_i(a_oe ? a_do : a_drv),
      .port_c_data_i(c_drv), .port_a_data_o(a_do), .port_a_data_oe_o(a_oe),
      .port_b_data_o(b_do), .first_mailbox_flag_n_o(mf1), .second_mailbox_flag_n_o(mf2),
      .cfg_o(cfg), .offsets_o(ofs), .a_to_b_queue_ptr_rst_o(ab_rst),
      .a_to_b_queue_write_o(ab_wr), .a_to_b_queue_wdata_o(ab_wd), .a_to_b_queue_read_o(ab_rd),
      .a_to_b_queue_rdata_i(ab_rdat), .c_to_a_queue_ptr_rst_o(ca_rst),
      .c_to_a_queue_write_o(ca_wr), .c_to_a_queue_wdata_o(ca_wd), .c_to_a_queue_read_o(ca_rd),
      .c_to_a_queue_rdata_i(ca_rdat));
   tpf_core_model core (.clk_i(clk_i), .ab_rst_i(ab_rst), .ab_wr_i(ab_wr), .ab_wdata_i(ab_wd),
      .ab_rd_i(ab_rd), .ab_rdata_o(ab_rdat), .ca_rst_i(ca_rst), .ca_wr_i(ca_wr),
      .ca_wdata_i(ca_wd), .ca_rd_i(ca_rd), .ca_rdata_o(ca_rdat));
   initial
   begin
      clk_i = 0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic complete_run();
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Each port clock level lasts 4 system cycles so the pin filter cannot miss it
   task automatic pulse(input int p);
      @(posedge clk_i);
      case (p)
         0: pa <= 1'b1;
         1: pb <= 1'b1;
         default: pc <= 1'b1;
      endcase
      repeat (4) @(posedge clk_i);
      pa <= 1'b0;
      pb <= 1'b0;
      pc <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : pulse
   task automatic mreset(input logic h, input logic l, input logic s, input logic e);
      @(posedge clk_i);
      master_reset_one_n_n <= 1'b0;
      master_reset_two_n_n <= 1'b0;
      c_mb <= 1'b1;
      hi <= h;
      lo <= l;
      spm_n <= s;
      ets <= e;
      bw <= h;
      cw <= ~h;
      for (int i = 0; i < 4; i++)
         for (int p = 0; p < 3; p++)
            pulse(p);
      master_reset_one_n_n <= 1'b1;
      master_reset_two_n_n <= 1'b1;
      repeat (8) @(posedge clk_i);
      c_mb <= 1'b0;
      hi <= 1'b1;
   endtask : mreset
   task automatic t_presets();
      logic [9:0] tbl [4] = '{10'h000, `TPF_OFS_8, `TPF_OFS_16, `TPF_OFS_64};
      for (int i = 0; i < 4; i++)
      begin
         mreset(i[1], i[0], 1'b1, i[0]);
         chk(cfg.method, i == 0 ? tpf_pkg::TPF_PARALLEL : tpf_pkg::TPF_PRESET);
         if (i > 0)
            chk(cfg.preset, tbl[i]);
         if (i > 0)
            chk(ofs, {4{tbl[i][7:0]}});
         chk(cfg.big_endian, i[0]);
         chk({cfg.b_byte, cfg.c_byte}, {i[1], ~i[1]});
         chk({mf1, mf2, b_do}, {2'b11, 18'h00000});
      end
      ets <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(cfg.fwft, 1'b1);
   endtask : t_presets
   task automatic t_first_mailbox();
      a_en <= 1'b1;
      a_wr <= 1'b1;
      a_mb <= 1'b1;
      a_drv <= 36'h900035a5a;
      pulse(0);
      chk(mf1, 1'b1);
      a_cs_n <= 1'b0;
      pulse(0);
      chk(mf1, 1'b0);
      a_drv <= 36'h000001111;
      pulse(0);
      a_cs_n <= 1'b1;
      b_mb <= 1'b1;
      b_ren <= 1'b1;
      pulse(1);
      chk(b_do, 18'h35a5a);
      chk(mf1, 1'b1);
   endtask : t_first_mailbox
   task automatic t_second_mailbox();
      c_mb <= 1'b1;
      c_drv <= 18'h2b6c9;
      pulse(2);
      chk(mf2, 1'b1);
      c_wen <= 1'b1;
      pulse(2);
      chk(mf2, 1'b0);
      c_drv <= 18'h01234;
      pulse(2);
      c_wen <= 1'b0;
      a_cs_n <= 1'b0;
      a_wr <= 1'b0;
      pulse(0);
      chk(a_oe, 1'b1);
      chk(a_do, 36'h00002b6c9);
      chk(mf2, 1'b1);
      a_wr <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(a_oe, 1'b0);
   endtask : t_second_mailbox
   task automatic t_queues();
      a_mb <= 1'b0;
      a_drv <= 36'h5c3a1e0f7;
      pulse(0);
      chk(core.ab_last, 36'h5c3a1e0f7);
      a_wr <= 1'b0;
      pulse(0);
      chk(a_do, 36'h00000c3c3);
      a_cs_n <= 1'b1;
      c_mb <= 1'b0;
      c_wen <= 1'b1;
      c_drv <= 18'h3e4d2;
      pulse(2);
      chk(core.ca_last, 18'h3e4d2);
      c_wen <= 1'b0;
      b_mb <= 1'b0;
      pulse(1);
      chk(b_do, 18'h000a5);
      b_ren <= 1'b0;
      pulse(1);
      chk(core.ab_idx, 8'h01);
   endtask : t_queues
   task automatic t_partial();
      partial_reset_one_n_n <= 1'b0;
      partial_reset_two_n_n <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({ab_rst, ca_rst}, 2'b11);
      partial_reset_one_n_n <= 1'b1;
      partial_reset_two_n_n <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(b_do, 18'h00000);
      chk(a_do, 36'h000000000);
      chk({mf1, mf2}, 2'b11);
      chk(cfg.preset, `TPF_OFS_64);
      chk(ofs, {4{8'h40}});
      chk({cfg.method, cfg.b_byte, cfg.c_byte}, {tpf_pkg::TPF_PRESET, 2'b10});
   endtask : t_partial
   task automatic t_serial();
      logic [31:0] pat = 32'hc35a96e1;
      mreset(1'b0, 1'b0, 1'b0, 1'b1);
      chk(cfg.method, tpf_pkg::TPF_SERIAL);
      // Serial enable was just raised by the reset task in this time step
      @(posedge clk_i);
      hi <= 1'b0;
      // The full image is shifted, one bit per port A clock
      for (int i = 31; i >= 0; i--)
      begin
         lo <= pat[i];
         pulse(0);
      end
      hi <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(ofs, pat);
   endtask : t_serial
   task automatic t_parallel();
      mreset(1'b0, 1'b0, 1'b1, 1'b1);
      a_en <= 1'b1;
      a_wr <= 1'b1;
      a_mb <= 1'b0;
      a_cs_n <= 1'b0;
      // The first four port A words load offsets and must not reach the queue
      for (int i = 1; i <= 4; i++)
      begin
         a_drv <= {28'h0000000, 4'(i), 4'(i)};
         pulse(0);
      end
      chk(ofs, 32'h11223344);
      chk(core.ab_last, 36'h5c3a1e0f7);
      a_drv <= 36'h0a5a5a5a5;
      pulse(0);
      chk(core.ab_last, 36'h0a5a5a5a5);
      chk(ofs, 32'h11223344);
      a_cs_n <= 1'b1;
   endtask : t_parallel
   initial
   begin
      {srst_i, master_reset_one_n_n, master_reset_two_n_n, partial_reset_one_n_n, partial_reset_two_n_n, hi, spm_n, a_cs_n} = 8'hff;
      {pa, pb, pc, lo, ets, bw, cw, a_en, a_wr, a_mb, b_ren, b_mb, c_wen, c_mb} = 14'h0000;
      a_drv = 36'h000000000;
      c_drv = 18'h00000;
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(a_oe, 1'b0);
      repeat (4) @(posedge clk_i);
      t_presets();
      t_first_mailbox();
      t_second_mailbox();
      t_queues();
      t_partial();
      t_serial();
      t_parallel();
      complete_run();
   end
   // The whole sequence needs about 1200 cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      complete_run();
   end
endmodule : tpf_ctrl_bench

// file: tpf_params.svh
`ifndef TPF_PARAMS_SVH
`define TPF_PARAMS_SVH
// Bus widths
`define TPF_A_W 36
`define TPF_BC_W 18
// Preset flag offsets
`define TPF_OFS_W 10
`define TPF_OFS_8 10'h008
`define TPF_OFS_16 10'h010
`define TPF_OFS_64 10'h040
// Default offset width is log2 of the smallest depth
`define TPF_DEPTH_LOG2 8
`define TPF_DEPTH_LOG2_MIN 8
`define TPF_DEPTH_LOG2_MAX 10
// Parallel load takes one port A word per offset register
`define TPF_OFS_REGS 4
// Reset values
`define TPF_FLAG_EMPTY 1'b1
`define TPF_OUT_CLR 36'h0
`endif

// file: tpf_pkg.sv
`include "tpf_params.svh"
package tpf_pkg;
   typedef enum logic [1:0] {
      TPF_PRESET = 2'b00,
      TPF_PARALLEL = 2'b01,
      TPF_SERIAL = 2'b10
   } tpf_method_e;

   // Device pins as sampled from outside
   typedef struct packed {
      logic a_clk;
      logic b_clk;
      logic c_clk;
      logic master_reset_one_n_n;
      logic master_reset_two_n_n;
      logic partial_reset_one_n_n;
      logic partial_reset_two_n_n;
      logic sel_hi;
      logic sel_lo;
      logic spm_n;
      logic ets;
      logic b_byte;
      logic c_byte;
      logic a_en;
      logic a_cs_n;
      logic a_wr;
      logic a_mb;
      logic b_ren;
      logic b_mb;
      logic c_wen;
      logic c_mb;
      logic [`TPF_A_W-1:0] a_data;
      logic [`TPF_BC_W-1:0] c_data;
   } tpf_pins_s;

   typedef struct packed {
      tpf_method_e method;
      logic [`TPF_OFS_W-1:0] preset;
      logic big_endian;
      logic fwft;
      logic b_byte;
      logic c_byte;
   } tpf_cfg_s;
endpackage : tpf_pkg
